// file: verilog/rx_signal_qualifiers.sv
/*
  receive qualifiers: sync gating, preamble quality, held signal strength,
  carrier sense and output pin selection.
  assumes bit strobes and raw strength samples arrive on i_sys_clk, and the
  demodulator reports raw sync matches with a match count.
*/
`timescale 1ns/1ps
`default_nettype none

module rx_signal_qualifiers #(
  parameter int PQ_WIDTH = 8,
  parameter int HYST_HALF_DB = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire rxq_pkg::rxq_cfg_t i_cfg,
  input wire logic i_rx_enter,
  input wire logic i_rx_active,
  input wire logic i_bit_valid,
  input wire logic i_bit,
  input wire logic i_sync_candidate,
  input wire logic [5:0] i_sync_match_bits,
  input wire logic i_strength_valid,
  input wire logic [7:0] i_strength_raw,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_payload_done,
  input wire logic [5:0] i_pin_select,
  output logic o_fifo_wr,
  output logic [7:0] o_fifo_data,
  output logic o_sync_found,
  output logic [7:0] o_signal_strength,
  output rxq_pkg::rxq_status_t o_packet_status,
  output logic o_general_output_pin
);

  // elaboration guard: the counter must hold 4 x 7 plus headroom
  if (PQ_WIDTH < 6 || PQ_WIDTH > 16)
  begin : g_bad_pq_width
    $error("preamble counter width out of range");
  end
  // hysteresis beyond 16 half dB would swallow the offset range
  if (HYST_HALF_DB < 0 || HYST_HALF_DB > 16)
  begin : g_bad_hyst
    $error("hysteresis out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // decoding helpers

  // sync match criterion for the low two mode bits
  function automatic logic match_ok(input logic [1:0] mode, input logic [5:0] n);
    case (mode)
      rxq_pkg::SYNC_15_16: match_ok = (n >= 6'd15) && (n <= 6'd16);
      rxq_pkg::SYNC_16_16: match_ok = (n == 6'd16);
      rxq_pkg::SYNC_30_32: match_ok = (n >= 6'd30);
      default: match_ok = 1'b0;
    endcase
  endfunction

  // signed half-dB to a wider signed value
  function automatic logic signed [9:0] widen(input logic [7:0] v);
    widen = {{2{v[7]}}, v};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // preamble quality counter
  // the first bit after entry has no predecessor and moves nothing;
  // the counter floors at zero and sticks at full scale, so a long
  // noisy run can never wrap round into a false preamble

  logic [PQ_WIDTH-1:0] pq_cnt_ff; // quality count, saturating
  logic [PQ_WIDTH-1:0] nxt_pq_cnt;
  logic prev_bit_ff; // last received bit
  logic have_prev_ff; // first bit after entry has no predecessor
  logic [PQ_WIDTH-1:0] pq_limit;
  wire logic bit_changed = i_bit != prev_bit_ff;
  wire logic pq_enabled = i_cfg.preamble_threshold != 3'h0;
  assign pq_limit = PQ_WIDTH'(rxq_pkg::PQ_THR_SCALE * i_cfg.preamble_threshold);
  wire logic pq_reached = pq_enabled && (pq_cnt_ff > pq_limit);

  // up by one on change, down by eight on repeat, clamped both ends
  always_comb
  begin
    nxt_pq_cnt = pq_cnt_ff;
    if (i_bit_valid && have_prev_ff)
    begin
      if (bit_changed)
      begin
        if (pq_cnt_ff != {PQ_WIDTH{1'b1}})
          nxt_pq_cnt = pq_cnt_ff + PQ_WIDTH'(rxq_pkg::PQ_INC);
      end
      else if (pq_cnt_ff > PQ_WIDTH'(rxq_pkg::PQ_DEC))
        nxt_pq_cnt = pq_cnt_ff - PQ_WIDTH'(rxq_pkg::PQ_DEC);
      else
        nxt_pq_cnt = '0; // floor rather than wrap
    end
  end

  // counter restarts on each entry to receive
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst || i_rx_enter)
    begin
      pq_cnt_ff <= '0;
      prev_bit_ff <= 1'b0;
      have_prev_ff <= 1'b0;
    end
    else
    begin
      pq_cnt_ff <= nxt_pq_cnt;
      if (i_bit_valid)
      begin
        prev_bit_ff <= i_bit;
        have_prev_ff <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // strength averaging: one sample in 2^filter_length is published
  // only the sample on the tick is kept and the ones between are dropped,
  // which trades true averaging for a single small counter;
  // a filter_length of 3 gives a period of eight samples

  logic [3:0] avg_cnt_ff; // samples since last publish
  logic [3:0] avg_len;
  assign avg_len = 4'(1) << i_cfg.filter_length;
  wire logic avg_tick = i_strength_valid && (avg_cnt_ff == avg_len - 4'h1);

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst || i_rx_enter)
      avg_cnt_ff <= 4'h0;
    else if (avg_tick)
      avg_cnt_ff <= 4'h0;
    else if (i_strength_valid)
      avg_cnt_ff <= avg_cnt_ff + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // carrier sense
  // both modes look only at published samples, so a longer filter slows
  // the carrier decision as well as the strength readout;
  // the absolute threshold is kept in reading units so that it can be
  // compared with the raw sample without any offset correction

  logic [7:0] cur_ff; // current strength sample, not frozen
  logic [7:0] prev_ff; // previous published sample
  logic cs_ff; // carrier sense level
  logic nxt_cs;
  logic signed [9:0] abs_thr; // threshold in half dB
  logic signed [9:0] rel_step;
  logic signed [9:0] cur_s;
  logic signed [9:0] delta;

  // base threshold grows with gain limits, offset and target in whole dB
  // a larger gain limit code caps the gain lower and so lifts the threshold
  assign abs_thr = 10'(rxq_pkg::CS_ABS_BASE)
    + 10'(signed'({7'h0, i_cfg.front_end_gain_limit}) * 10'sd6)
    + 10'(signed'({8'h0, i_cfg.digital_gain_limit}) * 10'sd12)
    + 10'(signed'({{6{i_cfg.absolute_threshold_offset[3]}},
        i_cfg.absolute_threshold_offset}) * 10'sd2)
    + 10'(signed'({7'h0, i_cfg.magnitude_target}) * 10'sd2);

  // relative step of 6, 10 or 14 dB in half dB units
  assign rel_step = (i_cfg.relative_threshold == 2'h1) ? 10'sd12
    : (i_cfg.relative_threshold == 2'h2) ? 10'sd20 : 10'sd28;
  assign cur_s = widen(i_strength_raw);
  assign delta = cur_s - widen(prev_ff);

  // relative mode wins when enabled; absolute holds with hysteresis
  always_comb
  begin
    nxt_cs = cs_ff;
    if (avg_tick)
    begin
      if (i_cfg.relative_threshold != rxq_pkg::REL_OFF)
      begin
        if (delta >= rel_step)
          nxt_cs = 1'b1;
        else if (-delta >= rel_step)
          nxt_cs = 1'b0;
      end
      else if (cur_s > abs_thr + 10'(HYST_HALF_DB))
        nxt_cs = 1'b1;
      else if (cur_s < abs_thr - 10'(HYST_HALF_DB))
        nxt_cs = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      cs_ff <= 1'b0;
      cur_ff <= rxq_pkg::SIGNAL_STRENGTH_RST;
      prev_ff <= rxq_pkg::SIGNAL_STRENGTH_RST;
    end
    else if (i_rx_enter)
      cs_ff <= 1'b0;
    else if (avg_tick)
    begin
      cs_ff <= nxt_cs;
      prev_ff <= i_strength_raw;
      cur_ff <= i_strength_raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sync acceptance
  // every qualifier is judged in the cycle of the candidate itself;
  // a qualifier that rises one cycle late does not rescue the candidate,
  // the demodulator has to report the next match instead

  logic sync_ff; // sync accepted in this reception
  wire logic mode_needs_cs = i_cfg.sync_mode[rxq_pkg::SYNC_CS_BIT];
  wire logic [1:0] mode_low = i_cfg.sync_mode[1:0];
  wire logic no_sync = mode_low == rxq_pkg::SYNC_NONE;
  wire logic cs_ok = !mode_needs_cs || cs_ff;
  wire logic pq_ok = !pq_enabled || pq_reached;
  wire logic accept = i_rx_active && !sync_ff && i_sync_candidate
    && match_ok(mode_low, i_sync_match_bits) && pq_ok && cs_ok;
  // with no sync search, data flows once carrier sense allows it
  wire logic open_path = no_sync && cs_ok;
  wire logic path_open = sync_ff || open_path;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst || i_rx_enter || !i_rx_active)
      sync_ff <= 1'b0;
    else if (accept)
      sync_ff <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // frozen strength and fifo path
  // a byte arriving with the pending status byte wins the slot, so the
  // appended byte waits for the first idle cycle rather than being lost

  logic [7:0] strength_ff; // status value, frozen after sync
  logic fifo_wr_ff;
  logic [7:0] fifo_data_ff;
  logic append_ff; // one status byte pending

  // tracks until sync, then holds until receive re-entered
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
      strength_ff <= rxq_pkg::SIGNAL_STRENGTH_RST;
    else if (i_rx_active && !sync_ff && avg_tick)
      strength_ff <= i_strength_raw;
  end

  // bytes only pass once the path opens; status byte follows payload
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      fifo_wr_ff <= 1'b0;
      fifo_data_ff <= 8'h00;
      append_ff <= 1'b0;
    end
    else
    begin
      fifo_wr_ff <= 1'b0;
      if (i_byte_valid && path_open)
      begin
        fifo_wr_ff <= 1'b1;
        fifo_data_ff <= i_byte;
      end
      else if (append_ff)
      begin
        fifo_wr_ff <= 1'b1;
        fifo_data_ff <= cur_ff;
      end
      if (i_payload_done && path_open && i_cfg.status_append_enable)
        append_ff <= 1'b1;
      else if (append_ff && !(i_byte_valid && path_open))
        append_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status and pin
  // every output leaves through a flop; status and pin therefore trail
  // their cause by two cycles, which the host must allow for when polling

  wire logic pin_next = (i_pin_select == rxq_pkg::PIN_SEL_PQ) ? pq_reached
    : (i_pin_select == rxq_pkg::PIN_SEL_CS) ? cs_ff : 1'b0;

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_nrst)
    begin
      o_packet_status <= '0;
      o_general_output_pin <= 1'b0;
      o_sync_found <= 1'b0;
      o_signal_strength <= rxq_pkg::SIGNAL_STRENGTH_RST;
    end
    else
    begin
      o_packet_status.carrier_sense <= cs_ff;
      o_packet_status.preamble_quality_reached <= pq_reached;
      o_packet_status.sync_found <= sync_ff;
      o_general_output_pin <= pin_next;
      o_sync_found <= sync_ff;
      o_signal_strength <= strength_ff;
    end
  end

  assign o_fifo_wr = fifo_wr_ff;
  assign o_fifo_data = fifo_data_ff;

endmodule // rx_signal_qualifiers

`default_nettype wire

// file: common/rxq_pkg.sv
/*
  package for the receive qualifier block: field codes, defaults, carriers.
  assumes a single synchronous clock domain and no register bus.
*/
package rxq_pkg;
  // sync qualifier mode codes, low two bits
  localparam logic [1:0] SYNC_NONE = 2'h0;
  localparam logic [1:0] SYNC_15_16 = 2'h1;
  localparam logic [1:0] SYNC_16_16 = 2'h2;
  localparam logic [1:0] SYNC_30_32 = 2'h3;
  // bit position of the carrier sense flag in the mode field
  localparam int SYNC_CS_BIT = 2;
  // preamble counter arithmetic
  localparam int PQ_INC = 1;
  localparam int PQ_DEC = 8;
  localparam int PQ_THR_SCALE = 4;
  // output pin select codes
  localparam logic [5:0] PIN_SEL_PQ = 6'h08;
  localparam logic [5:0] PIN_SEL_CS = 6'h0e;
  // defaults
  localparam logic [3:0] ABS_OFFSET_RST = 4'h0;
  localparam logic [2:0] MAGNITUDE_TARGET_RST = 3'h3;
  localparam logic [7:0] SIGNAL_STRENGTH_RST = 8'h80;
  // carrier sense base level in reading units: -100 dBm seen through a
  // front end offset of 74 dB, so every threshold lands inside 8 bits
  localparam int CS_ABS_BASE = -52;
  // relative threshold codes
  localparam logic [1:0] REL_OFF = 2'h0;

  // configuration carrier
  typedef struct packed {
    logic [2:0] sync_mode;
    logic [2:0] preamble_threshold;
    logic status_append_enable;
    logic [2:0] front_end_gain_limit;
    logic [1:0] digital_gain_limit;
    logic [3:0] absolute_threshold_offset;
    logic [1:0] relative_threshold;
    logic [2:0] magnitude_target;
    logic [1:0] filter_length;
  } rxq_cfg_t;

  // packet status carrier
  typedef struct packed {
    logic carrier_sense;
    logic preamble_quality_reached;
    logic sync_found;
  } rxq_status_t;
endpackage

// file: bench/rxq_host_model.sv
/*
  host side model: polls packet status and the output pin on request.
  assumes the block's clock and registered status outputs.
*/
`timescale 1ns/1ps
`default_nettype none
module rxq_host_model (
  input wire logic i_sys_clk,
  input wire logic i_rd,
  input wire rxq_pkg::rxq_status_t i_status,
  input wire logic i_pin,
  output logic [3:0] o_rd_data
);
  // one poll per strobe, pin on top; no refresh between polls
  always_ff @(posedge i_sys_clk)
  begin
    if (i_rd)
    begin
      o_rd_data <= {i_pin, i_status};
    end
  end
endmodule // rxq_host_model
`default_nettype wire

// file: bench/rx_signal_qualifiers_checker.sv
/*
  port checker for the receive qualifiers, bound to the block.
  assumes one clock and the synchronous active low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_signal_qualifiers_checker (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire rxq_pkg::rxq_cfg_t i_cfg,
  input wire logic i_rx_enter,
  input wire logic i_rx_active,
  input wire logic i_bit_valid,
  input wire logic i_bit,
  input wire logic i_sync_candidate,
  input wire logic [5:0] i_sync_match_bits,
  input wire logic i_strength_valid,
  input wire logic [7:0] i_strength_raw,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_payload_done,
  input wire logic [5:0] i_pin_select,
  input wire logic o_fifo_wr,
  input wire logic [7:0] o_fifo_data,
  input wire logic o_sync_found,
  input wire logic [7:0] o_signal_strength,
  input wire rxq_pkg::rxq_status_t o_packet_status,
  input wire logic o_general_output_pin
);
  ////////////////////////////////////////////////////////////
  // bits a candidate needs; 15/16 also takes a full match
  wire logic [1:0] mode = i_cfg.sync_mode[1:0];
  wire logic [5:0] need = (mode == rxq_pkg::SYNC_30_32) ? 6'h1e :
    (mode == rxq_pkg::SYNC_16_16) ? 6'h10 : 6'h0f;
  wire logic srch = (mode != rxq_pkg::SYNC_NONE);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////////////////////////
  strength_reset_a:
    assert property (!$past(i_nrst) |-> o_signal_strength == rxq_pkg::SIGNAL_STRENGTH_RST)
    else $error("strength not at reset value");
  fifo_gate_a:
    assert property (o_fifo_wr && srch |-> o_sync_found)
    else $error("fifo write before sync");
  sync_bits_a:
    assert property ($rose(o_sync_found) && srch |->
      $past(i_sync_candidate, 2) && $past(i_sync_match_bits, 2) >= need)
    else $error("sync without enough bits");
  sync_cs_a:
    assert property ($rose(o_sync_found) && srch && i_cfg.sync_mode[2] |->
      $past(o_packet_status.carrier_sense))
    else $error("sync without carrier");
  sync_pq_a:
    assert property ($rose(o_sync_found) && srch && i_cfg.preamble_threshold != 3'h0 |->
      $past(o_packet_status.preamble_quality_reached))
    else $error("sync without preamble");
  strength_hold_a:
    assert property (o_sync_found && $past(o_sync_found) && !$past(i_rx_enter) |->
      $stable(o_signal_strength))
    else $error("strength moved after sync");
  pin_pq_a:
    assert property ($past(i_pin_select) == rxq_pkg::PIN_SEL_PQ |->
      o_general_output_pin == o_packet_status.preamble_quality_reached)
    else $error("pin differs from preamble flag");
  pin_cs_a:
    assert property ($past(i_pin_select) == rxq_pkg::PIN_SEL_CS |->
      o_general_output_pin == o_packet_status.carrier_sense)
    else $error("pin differs from carrier flag");
  // main scenarios reached
  cover property ($rose(o_sync_found));
  cover property ($rose(o_packet_status.carrier_sense));
  cover property (o_fifo_wr && o_sync_found);
endmodule // rx_signal_qualifiers_checker
bind rx_signal_qualifiers rx_signal_qualifiers_checker u_rx_signal_qualifiers_checker (
  .i_sys_clk, .i_nrst, .i_cfg, .i_rx_enter, .i_rx_active, .i_bit_valid, .i_bit,
  .i_sync_candidate, .i_sync_match_bits, .i_strength_valid, .i_strength_raw,
  .i_byte_valid, .i_byte, .i_payload_done, .i_pin_select, .o_fifo_wr, .o_fifo_data,
  .o_sync_found, .o_signal_strength, .o_packet_status, .o_general_output_pin);
`default_nettype wire

// file: bench/test_rx_signal_qualifiers.sv
/*
  bench for the receive qualifiers: strobes bits, samples and bytes,
  polls status through the host model. assumes 40 MHz, low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module test_rx_signal_qualifiers;
  localparam int SAMP = 0;
  localparam int CAND = 1;
  localparam int BYTE = 2;
  localparam int DONE = 3;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  rxq_pkg::rxq_cfg_t cfg = '0;
  logic ent = 1'b0;
  logic act = 1'b1;
  logic bv_b = 1'b0;
  logic bit_d = 1'b0;
  logic cand = 1'b0;
  logic sv = 1'b0;
  logic bv = 1'b0;
  logic pdone = 1'b0;
  logic rd = 1'b0;
  logic [5:0] mbits = 6'h00;
  logic [5:0] psel = 6'h00;
  logic [7:0] sraw = 8'h00;
  logic [7:0] byte_d = 8'h00;
  logic [7:0] nwr = 8'h00;
  logic fwr, sfound, pin;
  logic [7:0] fdata, str, wcnt, wlast;
  logic [3:0] rdata;
  rxq_pkg::rxq_status_t stat;
  logic [5:0] need [1:3] = '{6'h0f, 6'h10, 6'h1e};
  logic [7:0] step [1:3] = '{8'h0c, 8'h14, 8'h1c};
  int error_cnt = 0;
  int cmp_count = 0;
  ////////////////////////////////////////////////////////////
  always #12.5 clk = ~clk;
  rx_signal_qualifiers u_rx_signal_qualifiers (.i_sys_clk(clk), .i_nrst(nrst),
    .i_cfg(cfg), .i_rx_enter(ent), .i_rx_active(act), .i_bit_valid(bv_b), .i_bit(bit_d),
    .i_sync_candidate(cand), .i_sync_match_bits(mbits), .i_strength_valid(sv),
    .i_strength_raw(sraw), .i_byte_valid(bv), .i_byte(byte_d), .i_payload_done(pdone),
    .i_pin_select(psel), .o_fifo_wr(fwr), .o_fifo_data(fdata), .o_sync_found(sfound),
    .o_signal_strength(str), .o_packet_status(stat), .o_general_output_pin(pin));
  rxq_host_model u_rxq_host_model (.i_sys_clk(clk), .i_rd(rd), .i_status(stat),
    .i_pin(pin), .o_rd_data(rdata));
  // tally of fifo writes, last byte kept
  always @(posedge clk)
  begin
    if (!nrst)
      wcnt <= 8'h00;
    else if (fwr === 1'b1)
    begin
      wcnt <= wcnt + 8'h01;
      wlast <= fdata;
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one strobe of the chosen kind, then settle past the output flops
  task automatic pulse(input int w, input logic [7:0] v);
    {sraw, mbits, byte_d} = {v, v[5:0], v};
    {sv, cand, bv, pdone} = {w == SAMP, w == CAND, w == BYTE, w == DONE};
    tick(1);
    {sv, cand, bv, pdone} = 4'h0;
    tick(3);
  endtask
  task automatic bits(input logic [7:0] v, input int n);
    for (int k = n - 1; k >= 0; k--)
    begin
      bit_d = v[k];
      bv_b = 1'b1;
      tick(1);
    end
    bv_b = 1'b0;
    tick(3);
  endtask
  task automatic enter();
    {ent, act} = 2'b10;
    tick(1);
    {ent, act} = 2'b01;
    tick(3);
  endtask
  task automatic st(input logic [3:0] exp, input logic [3:0] msk);
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    chk({4'h0, rdata & msk}, {4'h0, exp}, "status");
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    tick(12);
    nrst = 1'b1;
    tick(1);
    st(4'h0, 4'hf);
    chk(str, rxq_pkg::SIGNAL_STRENGTH_RST, "reset strength");
    pulse(BYTE, 8'h33);
    nwr++;
    chk(wcnt, nwr, "open byte");
    $display("test reset done");
    for (int i = 1; i < 4; i++)
    begin
      cfg.sync_mode = 3'(i);
      enter();
      pulse(SAMP, 8'hc4);
      chk(str, 8'hc4, "live strength");
      pulse(BYTE, 8'h11);
      chk(wcnt, nwr, "early byte");
      pulse(CAND, {2'h0, need[i] - 6'h01});
      chk({7'h0, sfound}, 8'h00, "short match");
      pulse(CAND, {2'h0, need[i]});
      chk({7'h0, sfound}, 8'h01, "match");
      pulse(BYTE, 8'h22);
      nwr++;
      chk(wcnt, nwr, "payload");
      pulse(SAMP, 8'h50);
      chk(str, 8'hc4, "held strength");
    end
    $display("test sync modes done");
    {cfg.sync_mode, cfg.preamble_threshold, psel} = {3'h2, 3'h1, rxq_pkg::PIN_SEL_PQ};
    enter();
    bits(8'h0a, 5);
    st(4'h0, 4'hb);
    bits(8'h01, 1);
    st(4'ha, 4'hb);
    bits(8'h15, 5);
    st(4'h0, 4'hb);
    pulse(CAND, 8'h10);
    st(4'h0, 4'hb);
    bits(8'h00, 1);
    pulse(CAND, 8'h10);
    st(4'hb, 4'hb);
    $display("test preamble done");
    {cfg.sync_mode, cfg.preamble_threshold, psel} = {3'h6, 3'h0, rxq_pkg::PIN_SEL_CS};
    for (int i = 1; i < 4; i++)
    begin
      cfg.relative_threshold = 2'(i);
      enter();
      pulse(SAMP, 8'he0);
      pulse(SAMP, 8'hde + step[i]);
      pulse(CAND, 8'h10);
      st(4'h0, 4'hd);
      pulse(SAMP, 8'he0 + step[i] + step[i]);
      st(4'hc, 4'hd);
      pulse(SAMP, 8'he2 + step[i]);
      st(4'hc, 4'hd);
      pulse(SAMP, 8'he0);
      st(4'h0, 4'hd);
      pulse(SAMP, 8'he2 + step[i]);
      pulse(CAND, 8'h10);
      st(4'hd, 4'hd);
    end
    $display("test carrier sense done");
    {cfg.sync_mode, cfg.relative_threshold, cfg.status_append_enable} = {3'h1, 2'h0, 1'b1};
    enter();
    pulse(CAND, 8'h10);
    pulse(BYTE, 8'ha5);
    pulse(SAMP, 8'h77);
    pulse(DONE, 8'h00);
    tick(8);
    nwr = nwr + 8'h02;
    chk(wlast, 8'h77, "appended strength");
    chk(wcnt, nwr, "append count");
    $display("test append done");
    // absolute carrier sense, one strength in two published
    cfg.sync_mode = 3'h4;
    cfg.filter_length = 2'h1;
    cfg.absolute_threshold_offset = rxq_pkg::ABS_OFFSET_RST;
    cfg.magnitude_target = rxq_pkg::MAGNITUDE_TARGET_RST;
    enter();
    pulse(SAMP, 8'hd6);
    st(4'h0, 4'hc);
    pulse(SAMP, 8'hd6);
    st(4'hc, 4'hc);
    pulse(BYTE, 8'h44);
    nwr++;
    chk(wcnt, nwr, "carrier byte");
    pulse(SAMP, 8'hd1);
    pulse(SAMP, 8'hd1);
    st(4'hc, 4'hc);
    pulse(SAMP, 8'hcf);
    pulse(SAMP, 8'hcf);
    st(4'h0, 4'hc);
    pulse(BYTE, 8'h45);
    chk(wcnt, nwr, "no carrier byte");
    cfg.absolute_threshold_offset = 4'h9;
    pulse(SAMP, 8'hcf);
    pulse(SAMP, 8'hcf);
    st(4'hc, 4'hc);
    psel = 6'h01;
    tick(2);
    st(4'h4, 4'hc);
    // raise the threshold: front end and digital gain caps lowered together
    cfg.front_end_gain_limit = 3'h7;
    cfg.digital_gain_limit = 2'h1;
    pulse(SAMP, 8'hcf);
    pulse(SAMP, 8'hcf);
    st(4'h0, 4'hc);
    pulse(SAMP, 8'h00);
    pulse(SAMP, 8'h00);
    st(4'h4, 4'hc);
    $display("test absolute done");
    test_done();
  end
  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    test_done();
  end
endmodule // test_rx_signal_qualifiers
`default_nettype wire
